// *** design/second_delay.sv ***
// Seconds-resolution delay timer for the trigger path.
// Assumes start is a one-cycle pulse; done pulses once when the count runs out.
module second_delay #(
  parameter int unsigned CYC_PER_S = supply_ctl_pkg::CYCLES_PER_SECOND
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [15:0] seconds,
  output logic             done
);
  import supply_ctl_pkg::*;

  logic [31:0] tick_reg;
  logic [31:0] tick_next;
  logic [15:0] sec_reg;
  logic [15:0] sec_next;
  logic        run_reg;
  logic        run_next;
  logic        done_reg;
  logic        done_next;

  always_comb begin
    tick_next = tick_reg;
    sec_next  = sec_reg;
    run_next  = run_reg;
    done_next = 1'b0;
    // Start wins: the caller still shows abort in the cycle it starts
    if (start) begin
      // Zero delay still costs one cycle so the path is uniform
      tick_next = 32'h00000000;
      sec_next  = seconds;
      run_next  = (seconds != 16'h0000);
      done_next = (seconds == 16'h0000);
    end else if (abort) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      if (tick_reg == CYC_PER_S - 1) begin
        tick_next = 32'h00000000;
        sec_next  = sec_reg - 16'h0001;
        if (sec_reg == 16'h0001) begin
          run_next  = 1'b0;
          done_next = 1'b1;
        end
      end else begin
        tick_next = tick_reg + 32'h00000001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_reg <= 32'h00000000;
      sec_reg  <= 16'h0000;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      sec_reg  <= sec_next;
      run_reg  <= run_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule // second_delay

// *** design/supply_ctl_pkg.sv ***
// Package: register map, field positions, reset values and timing for the supply control block.
// Assumes a 40 MHz hclk and an AHB-Lite register bus with 32-bit words.
package supply_ctl_pkg;
  localparam int unsigned CLK_HZ              = 40_000_000;
  localparam int unsigned SECOND_S            = 1;
  localparam int unsigned CYCLES_PER_SECOND   = CLK_HZ * SECOND_S;
  localparam logic [15:0] TRIG_DELAY_MAX_S    = 16'h0E10;
  localparam logic [15:0] TRIG_DELAY_RESET_S  = 16'h0000;
  // Set-points in 100 uV units, 20 bits
  localparam int unsigned VW                  = 20;
  localparam logic [19:0] VSTEP_MIN_A         = 20'h00004;
  localparam logic [19:0] VSTEP_MIN_B         = 20'h0000A;
  localparam logic [19:0] VMAX_LOW            = 20'h141E0;
  localparam logic [19:0] VMAX_HIGH           = 20'h324B0;
  localparam logic [19:0] IMAX_LOW            = 20'h324B0;
  localparam logic [19:0] IMAX_HIGH           = 20'h19258;
  localparam logic [19:0] OVP_RESET           = 20'h35B60;
  localparam logic [19:0] VOLT_RESET          = 20'h00000;
  // Register byte offsets
  localparam logic [7:0] A_CMD      = 8'h00;
  localparam logic [7:0] A_VOLT     = 8'h04;
  localparam logic [7:0] A_STEP     = 8'h08;
  localparam logic [7:0] A_VTRIG    = 8'h0C;
  localparam logic [7:0] A_OVP      = 8'h10;
  localparam logic [7:0] A_CTRL     = 8'h14;
  localparam logic [7:0] A_DELAY    = 8'h18;
  localparam logic [7:0] A_STATUS   = 8'h1C;
  localparam logic [7:0] A_STEPDEF  = 8'h20;
  localparam logic [7:0] A_VTRIGMAX = 8'h24;
  localparam logic [7:0] A_IMAX     = 8'h28;
  // Command bits (write-one pulses at A_CMD)
  localparam int unsigned C_UP       = 0;
  localparam int unsigned C_DOWN     = 1;
  localparam int unsigned C_STEPDEF  = 2;
  localparam int unsigned C_OVPCLR   = 3;
  localparam int unsigned C_INIT     = 4;
  localparam int unsigned C_TRG      = 5;
  localparam int unsigned C_IFRESET  = 6;
  localparam int unsigned C_REMOTE   = 7;
  localparam int unsigned C_OPC      = 8;
  localparam int unsigned C_WAI      = 9;
  // Control fields
  localparam int unsigned F_OVP_EN   = 0;
  localparam int unsigned F_RANGE    = 1;
  localparam int unsigned F_SRC      = 2;
  // Status fields
  localparam int unsigned S_TRIPPED  = 0;
  localparam int unsigned S_ARMED    = 1;
  localparam int unsigned S_BUSY     = 2;
  localparam int unsigned S_OPC_EVT  = 3;
  localparam int unsigned S_OPC_QRY  = 4;
  localparam int unsigned S_REMOTE   = 5;
  localparam int unsigned S_VTPROG   = 6;
  localparam int unsigned S_CROWBAR  = 7;
  localparam logic RANGE_LOW   = 1'b0;
  localparam logic SRC_BUS     = 1'b0;
  localparam logic SRC_INSTANT = 1'b1;
  typedef enum logic [1:0] {
    TRIG_IDLE  = 2'b00,
    TRIG_ARMED = 2'b01,
    TRIG_WAIT  = 2'b11
  } trig_state_t;
endpackage : supply_ctl_pkg

// *** design/supply_setpoint_trigger_protection.sv ***
// Voltage set-point, trigger and overvoltage control behind an AHB-Lite slave.
// Assumes one AHB-Lite master, word transfers, and an analog overvoltage comparator input.
module supply_setpoint_trigger_protection #(
  parameter logic                  MODEL_B   = 1'b0,
  parameter int unsigned           CYC_PER_S = supply_ctl_pkg::CYCLES_PER_SECOND
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Analog side
  input  wire logic        excess_potential_flag,
  input  wire logic        bus_get,
  output logic [19:0]      volt_setpoint,
  output logic             crowbar_fire,
  output logic             trig_applied
);
  import supply_ctl_pkg::*;

  function automatic logic [19:0] clamp_v(input logic [20:0] v, input logic rng);
    logic [19:0] lim;
    lim = (rng == RANGE_LOW) ? VMAX_LOW : VMAX_HIGH;
    clamp_v = (v > {1'b0, lim}) ? lim : v[19:0];
  endfunction

  logic [19:0] step_min;
  assign step_min = MODEL_B ? VSTEP_MIN_B : VSTEP_MIN_A;

  // Bus address phase capture
  logic       ph_wr_reg, ph_wr_next;
  logic       ph_rd_reg, ph_rd_next;
  logic [7:0] ph_a_reg, ph_a_next;
  logic       stall;
  logic       rd_wait;
  logic       rd_done_reg, rd_done_next;
  logic       take;
  assign take = hsel && hready && htrans[1];
  // One wait state per read so hrdata comes from a flop
  assign rd_wait = ph_rd_reg && !rd_done_reg;

  // Control state
  logic [19:0]  volt_reg, volt_next;
  logic [19:0]  step_reg, step_next;
  logic [19:0]  vtrig_reg, vtrig_next;
  logic         vtprog_reg, vtprog_next;
  logic [19:0]  ovp_reg, ovp_next;
  logic         ovp_en_reg, ovp_en_next;
  logic         range_reg, range_next;
  logic         src_reg, src_next;
  logic [15:0]  delay_reg, delay_next;
  logic         tripped_reg, tripped_next;
  logic [19:0]  saved_reg, saved_next;
  logic         remote_reg, remote_next;
  logic         opc_evt_reg, opc_evt_next;
  logic         opc_qry_reg, opc_qry_next;
  logic         opc_arm_reg, opc_arm_next;
  logic         wai_reg, wai_next;
  logic         applied_reg, applied_next;
  trig_state_t  ts_reg, ts_next;
  logic         dly_start;
  logic         dly_done;
  logic [31:0]  rdata_next;
  logic [31:0]  rdata_reg;

  second_delay #(.CYC_PER_S(CYC_PER_S)) u_delay (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (dly_start),
    .abort   (ts_reg != TRIG_WAIT),
    .seconds (delay_reg),
    .done    (dly_done)
  );

  logic busy;
  assign busy  = (ts_reg == TRIG_WAIT);
  // Wait holds the bus off so no later command lands mid-trigger
  assign stall = wai_reg && busy;

  logic [31:0] cmd;
  logic        wr_go;
  assign wr_go = ph_wr_reg && !stall;
  assign cmd   = (wr_go && ph_a_reg == A_CMD) ? hwdata : 32'h00000000;

  always_comb begin
    ph_wr_next   = ph_wr_reg;
    ph_rd_next   = ph_rd_reg;
    ph_a_next    = ph_a_reg;
    rd_done_next = rd_wait;
    if (!stall && !rd_wait) begin
      ph_wr_next = take && hwrite;
      ph_rd_next = take && !hwrite;
      ph_a_next  = haddr[7:0];
    end
  end

  always_comb begin
    volt_next    = volt_reg;
    step_next    = step_reg;
    vtrig_next   = vtrig_reg;
    vtprog_next  = vtprog_reg;
    ovp_next     = ovp_reg;
    ovp_en_next  = ovp_en_reg;
    range_next   = range_reg;
    src_next     = src_reg;
    delay_next   = delay_reg;
    tripped_next = tripped_reg;
    saved_next   = saved_reg;
    remote_next  = remote_reg;
    opc_evt_next = opc_evt_reg;
    opc_qry_next = opc_qry_reg;
    opc_arm_next = opc_arm_reg;
    wai_next     = wai_reg && busy;
    applied_next = 1'b0;
    ts_next      = ts_reg;
    dly_start    = 1'b0;
    if (wr_go) begin
      if (ph_a_reg == A_VOLT) begin
        volt_next = clamp_v({1'b0, hwdata[19:0]}, range_reg);
      end else if (ph_a_reg == A_STEP) begin
        step_next = hwdata[19:0];
      end else if (ph_a_reg == A_VTRIG) begin
        vtrig_next  = clamp_v({1'b0, hwdata[19:0]}, range_reg);
        vtprog_next = 1'b1;
      end else if (ph_a_reg == A_OVP) begin
        ovp_next = hwdata[19:0];
      end else if (ph_a_reg == A_CTRL) begin
        ovp_en_next = hwdata[F_OVP_EN];
        range_next  = hwdata[F_RANGE];
        src_next    = hwdata[F_SRC];
        volt_next   = clamp_v({1'b0, volt_reg}, hwdata[F_RANGE]);
      end else if (ph_a_reg == A_DELAY) begin
        delay_next = (hwdata[15:0] > TRIG_DELAY_MAX_S) ? TRIG_DELAY_MAX_S : hwdata[15:0];
      end
    end
    if (cmd[C_STEPDEF]) begin
      step_next = step_min;
    end
    if (cmd[C_UP]) begin
      volt_next = clamp_v({1'b0, volt_reg} + {1'b0, step_reg}, range_reg);
    end else if (cmd[C_DOWN]) begin
      volt_next = (volt_reg > step_reg) ? volt_reg - step_reg : 20'h00000;
    end
    if (cmd[C_REMOTE]) begin
      remote_next = 1'b1;
    end
    if (cmd[C_IFRESET]) begin
      src_next = SRC_BUS;
      ts_next  = TRIG_IDLE;
    end
    if (cmd[C_OPC]) begin
      opc_arm_next = 1'b1;
      opc_qry_next = 1'b0;
    end
    if (cmd[C_WAI]) begin
      wai_next = busy;
    end
    case (ts_reg)
      TRIG_IDLE: begin
        if (cmd[C_INIT]) begin
          if (src_reg == SRC_INSTANT) begin
            volt_next    = clamp_v({1'b0, vtprog_reg ? vtrig_reg : volt_reg}, range_reg);
            applied_next = 1'b1;
          end else begin
            ts_next = TRIG_ARMED;
          end
        end
      end
      TRIG_ARMED: begin
        // Serial hosts must be in remote before the software trigger
        if ((cmd[C_TRG] && remote_reg) || bus_get) begin
          ts_next   = TRIG_WAIT;
          dly_start = 1'b1;
        end
      end
      TRIG_WAIT: begin
        if (dly_done) begin
          volt_next    = clamp_v({1'b0, vtprog_reg ? vtrig_reg : volt_reg}, range_reg);
          applied_next = 1'b1;
          ts_next      = TRIG_IDLE;
        end
      end
      default: begin
        ts_next = TRIG_IDLE;
      end
    endcase
    if (applied_next && (opc_arm_reg || cmd[C_OPC])) begin
      opc_evt_next = 1'b1;
      opc_qry_next = 1'b1;
      opc_arm_next = 1'b0;
    end
    if (tripped_reg && cmd[C_OVPCLR]) begin
      tripped_next = 1'b0;
      volt_next    = saved_reg;
    end
    // Clear wins: a trip cannot latch while tripped_reg is still set
    if (ovp_en_reg && excess_potential_flag && !tripped_reg) begin
      tripped_next = 1'b1;
      saved_next   = volt_reg;
    end
    if (wr_go && ph_a_reg == A_STATUS && hwdata[S_OPC_EVT] && !applied_next) begin
      opc_evt_next = 1'b0;
    end
  end

  always_comb begin
    rdata_next = 32'h00000000;
    if (ph_a_reg == A_VOLT) begin
      rdata_next = {12'h000, volt_reg};
    end else if (ph_a_reg == A_STEP) begin
      rdata_next = {12'h000, step_reg};
    end else if (ph_a_reg == A_STEPDEF) begin
      rdata_next = {12'h000, step_min};
    end else if (ph_a_reg == A_VTRIG) begin
      rdata_next = {12'h000, vtprog_reg ? vtrig_reg : volt_reg};
    end else if (ph_a_reg == A_VTRIGMAX) begin
      rdata_next = {12'h000, (range_reg == RANGE_LOW) ? VMAX_LOW : VMAX_HIGH};
    end else if (ph_a_reg == A_IMAX) begin
      rdata_next = {12'h000, (range_reg == RANGE_LOW) ? IMAX_LOW : IMAX_HIGH};
    end else if (ph_a_reg == A_OVP) begin
      rdata_next = {12'h000, ovp_reg};
    end else if (ph_a_reg == A_CTRL) begin
      rdata_next = {29'h00000000, src_reg, range_reg, ovp_en_reg};
    end else if (ph_a_reg == A_DELAY) begin
      rdata_next = {16'h0000, delay_reg};
    end else if (ph_a_reg == A_STATUS) begin
      rdata_next = {24'h000000, tripped_reg, vtprog_reg, remote_reg, opc_qry_reg,
                    opc_evt_reg, busy, ts_reg == TRIG_ARMED, tripped_reg};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_reg   <= 1'b0;
      ph_rd_reg   <= 1'b0;
      ph_a_reg    <= 8'h00;
      volt_reg    <= VOLT_RESET;
      step_reg    <= MODEL_B ? VSTEP_MIN_B : VSTEP_MIN_A;
      vtrig_reg   <= VOLT_RESET;
      vtprog_reg  <= 1'b0;
      ovp_reg     <= OVP_RESET;
      ovp_en_reg  <= 1'b1;
      range_reg   <= RANGE_LOW;
      src_reg     <= SRC_BUS;
      delay_reg   <= TRIG_DELAY_RESET_S;
      tripped_reg <= 1'b0;
      saved_reg   <= VOLT_RESET;
      remote_reg  <= 1'b0;
      opc_evt_reg <= 1'b0;
      opc_qry_reg <= 1'b0;
      opc_arm_reg <= 1'b0;
      wai_reg     <= 1'b0;
      rd_done_reg <= 1'b0;
      applied_reg <= 1'b0;
      ts_reg      <= TRIG_IDLE;
      rdata_reg   <= 32'h00000000;
    end else begin
      ph_wr_reg   <= ph_wr_next;
      ph_rd_reg   <= ph_rd_next;
      ph_a_reg    <= ph_a_next;
      volt_reg    <= volt_next;
      step_reg    <= step_next;
      vtrig_reg   <= vtrig_next;
      vtprog_reg  <= vtprog_next;
      ovp_reg     <= ovp_next;
      ovp_en_reg  <= ovp_en_next;
      range_reg   <= range_next;
      src_reg     <= src_next;
      delay_reg   <= delay_next;
      tripped_reg <= tripped_next;
      saved_reg   <= saved_next;
      remote_reg  <= remote_next;
      opc_evt_reg <= opc_evt_next;
      opc_qry_reg <= opc_qry_next;
      opc_arm_reg <= opc_arm_next;
      wai_reg     <= wai_next;
      rd_done_reg <= rd_done_next;
      applied_reg <= applied_next;
      ts_reg      <= ts_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign hrdata        = rdata_reg;
  assign hreadyout     = !stall && !rd_wait;
  assign hresp         = 1'b0;
  assign volt_setpoint = volt_reg;
  assign crowbar_fire  = tripped_reg;
  assign trig_applied  = applied_reg;

  a_trip_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    ovp_en_reg && excess_potential_flag && !tripped_reg |=> tripped_reg && crowbar_fire)
    else $error("trip not latched");
  a_clear_restores: assert property (@(posedge hclk) disable iff (!hresetn)
    tripped_reg && cmd[C_OVPCLR] && !excess_potential_flag |=> !tripped_reg
      && volt_reg == $past(saved_reg) && $stable(ovp_reg))
    else $error("clear did not restore");
  a_step_default: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd[C_STEPDEF] |=> step_reg == step_min)
    else $error("default step wrong");
  a_volt_up: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd[C_UP] && !applied_next && !(tripped_reg && cmd[C_OVPCLR])
      && ({1'b0, volt_reg} + {1'b0, step_reg}) <= {1'b0, VMAX_LOW}
      |=> volt_reg == $past(volt_reg) + $past(step_reg))
    else $error("up step wrong");
  a_instant_apply: assert property (@(posedge hclk) disable iff (!hresetn)
    ts_reg == TRIG_IDLE && cmd[C_INIT] && src_reg == SRC_INSTANT && !tripped_reg
      |=> trig_applied && ts_reg == TRIG_IDLE)
    else $error("instant initiate failed");
  a_bus_arm: assert property (@(posedge hclk) disable iff (!hresetn)
    ts_reg == TRIG_IDLE && cmd[C_INIT] && src_reg == SRC_BUS && !cmd[C_IFRESET]
      |=> ts_reg == TRIG_ARMED && !trig_applied)
    else $error("bus initiate did not arm");
  a_zero_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    ts_reg == TRIG_ARMED && bus_get && delay_reg == 16'h0000 && !cmd[C_IFRESET]
      |=> ##1 trig_applied)
    else $error("zero delay trigger late");
  a_wait_stall: assert property (@(posedge hclk) disable iff (!hresetn)
    wai_reg && busy |-> !hreadyout)
    else $error("wait did not stall");
  a_delay_max: assert property (@(posedge hclk) disable iff (!hresetn)
    delay_reg <= TRIG_DELAY_MAX_S)
    else $error("delay over max");
  a_range_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
    volt_reg <= ((range_reg == RANGE_LOW) ? VMAX_LOW : VMAX_HIGH))
    else $error("voltage over range");

  c_instant: cover property (@(posedge hclk) disable iff (!hresetn)
    cmd[C_INIT] && src_reg == SRC_INSTANT);
  c_bus_trig: cover property (@(posedge hclk) disable iff (!hresetn)
    ts_reg == TRIG_WAIT ##1 trig_applied);
  c_trip_clear: cover property (@(posedge hclk) disable iff (!hresetn)
    tripped_reg ##1 !tripped_reg);
  c_stall: cover property (@(posedge hclk) disable iff (!hresetn) stall);
endmodule // supply_setpoint_trigger_protection

// *** tb/remote_host.sv ***
// Host-side model: AHB-Lite master for single word transfers plus the group execute trigger.
// Assumes the slave's hreadyout is the bus hready and reads show up registered.
module remote_host (
  // Clock
  input  wire logic        hclk,
  // AHB-Lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  // Trigger message
  output logic             bus_get
);
  initial begin
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h5A5A_A5A5;
    bus_get = 1'b0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // The slave adds a wait state per read, so one transfer carries the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask

  task automatic get_pulse();
    @(posedge hclk);
    bus_get <= 1'b1;
    @(posedge hclk);
    bus_get <= 1'b0;
  endtask
endmodule // remote_host

// *** tb/supply_setpoint_trigger_protection_tb_top.sv ***
// Self-checking bench for the supply control block against an integer reference model.
// Assumes the remote_host master model and a 10-cycle second for short delays.
module supply_setpoint_trigger_protection_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import supply_ctl_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
  logic        excess_potential_flag, bus_get, crowbar_fire, trig_applied;
  logic [31:0] haddr, hwdata, hrdata, r, tmp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [19:0] volt_setpoint;
  logic [31:0] seed = 32'hB828;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          m_volt, m_step, m_vtrig;

  assign hready = hreadyout;

  supply_setpoint_trigger_protection #(.MODEL_B(1'b0), .CYC_PER_S(10)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .excess_potential_flag(excess_potential_flag),
    .bus_get(bus_get), .volt_setpoint(volt_setpoint), .crowbar_fire(crowbar_fire),
    .trig_applied(trig_applied));

  remote_host i_host (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .bus_get(bus_get));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_host.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(logic [7:0] a);
    i_host.rd(a, r);
  endtask

  task automatic cmd(int b);
    wr(A_CMD, 32'h1 << b);
  endtask

  // Outputs are looked at on the falling edge, where they have settled
  task automatic chkv(int exp);
    @(negedge hclk);
    chk("volt_setpoint", {12'h0, volt_setpoint}, exp);
  endtask

  task automatic wait_applied();
    int k;
    k = 0;
    while (trig_applied !== 1'b1 && k < 100) begin
      @(negedge hclk);
      k++;
    end
    chk("trig_applied seen", k < 100, 1);
    m_volt = m_vtrig;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    hresetn = 1'b0;
    excess_potential_flag = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(A_STEP);    chk("step", r, {12'h0, VSTEP_MIN_A});
    rd(A_CTRL);    chk("ctrl", r, 32'h1);
    rd(A_DELAY);   chk("delay", r, 32'h0);
    rd(A_OVP);     chk("ovp level", r, {12'h0, OVP_RESET});
    rd(A_VTRIG);   chk("vtrig", r, 32'h0);
    rd(A_STEPDEF); chk("stepdef", r, {12'h0, VSTEP_MIN_A});
    rd(8'h3C);     chk("unmapped", r, 32'h0);
    chk("hresp", hresp, 1'b0);
    $display("test reset values done");

    tmp = xs();
    m_step = (tmp & 32'hFF) + 1;
    m_volt = 32'h1000;
    wr(A_STEP, m_step);
    wr(A_VOLT, m_volt);
    for (int i = 0; i < 6; i++) begin
      tmp = xs();
      if (tmp[0]) begin
        cmd(C_UP);
        m_volt += m_step;
      end else begin
        cmd(C_DOWN);
        m_volt -= m_step;
      end
      chkv(m_volt);
    end
    rd(A_STEP); chk("step", r, m_step);
    cmd(C_STEPDEF);
    rd(A_STEP); chk("step", r, {12'h0, VSTEP_MIN_A});
    $display("test stepping done");

    wr(A_DELAY, 32'h3);
    m_vtrig = m_volt + 32'h200;
    wr(A_VTRIG, m_vtrig);
    m_volt = 32'h50;
    wr(A_VOLT, m_volt);
    rd(A_VTRIG); chk("vtrig", r, m_vtrig);
    wr(A_CTRL, 32'h5);
    rd(A_CTRL); chk("ctrl", r, 32'h5);
    cmd(C_INIT);
    repeat (3) @(posedge hclk);
    chkv(m_vtrig);
    m_volt = m_vtrig;
    $display("test instant trigger done");

    wr(A_CTRL, 32'h1);
    rd(A_CTRL); chk("ctrl", r, 32'h1);
    wr(A_DELAY, 32'h1);
    m_vtrig = 32'h3000;
    wr(A_VTRIG, m_vtrig);
    cmd(C_INIT);
    rd(A_STATUS); chk("armed", r & 32'h2, 32'h2);
    chkv(m_volt);
    i_host.get_pulse();
    repeat (5) @(posedge hclk);
    chkv(m_volt);
    wait_applied();
    chkv(m_vtrig);
    cmd(C_REMOTE);
    m_vtrig = 32'h2345;
    wr(A_VTRIG, m_vtrig);
    cmd(C_INIT);
    cmd(C_TRG);
    wr(A_CMD, (32'h1 << C_WAI) | (32'h1 << C_OPC));
    rd(A_STATUS); chk("opc flags", r & 32'h18, 32'h18);
    chkv(m_vtrig);
    m_volt = m_vtrig;
    wr(A_CTRL, 32'h5);
    cmd(C_IFRESET);
    rd(A_CTRL); chk("source", r & 32'h4, 32'h0);
    wr(A_DELAY, 32'h0);
    m_vtrig = 32'h1234;
    wr(A_VTRIG, m_vtrig);
    cmd(C_INIT);
    i_host.get_pulse();
    wait_applied();
    chkv(m_vtrig);
    $display("test bus trigger done");

    for (int h = 0; h < 2; h++) begin
      wr(A_CTRL, 32'h1 | (h << 1));
      rd(A_CTRL);     chk("range", r, 32'h1 | (h << 1));
      rd(A_VTRIGMAX); chk("vmax", r, {12'h0, h ? VMAX_HIGH : VMAX_LOW});
      rd(A_IMAX);     chk("imax", r, {12'h0, h ? IMAX_HIGH : IMAX_LOW});
    end
    $display("test ranges done");

    wr(A_CTRL, 32'h1);
    wr(A_OVP, 32'h1000);
    @(posedge hclk);
    excess_potential_flag <= 1'b1;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk("crowbar", crowbar_fire, 1'b1);
    rd(A_STATUS); chk("tripped", r & 32'h81, 32'h81);
    @(posedge hclk);
    excess_potential_flag <= 1'b0;
    cmd(C_OVPCLR);
    rd(A_STATUS); chk("tripped", r & 32'h81, 32'h0);
    rd(A_OVP);    chk("ovp level", r, 32'h1000);
    chkv(m_volt);
    chk("crowbar", crowbar_fire, 1'b0);
    wr(A_CTRL, 32'h0);
    rd(A_CTRL); chk("guard", r, 32'h0);
    @(posedge hclk);
    excess_potential_flag <= 1'b1;
    repeat (4) @(posedge hclk);
    @(negedge hclk);
    chk("crowbar", crowbar_fire, 1'b0);
    @(posedge hclk);
    excess_potential_flag <= 1'b0;
    $display("test overvoltage done");
    summarize();
  end
endmodule // supply_setpoint_trigger_protection_tb_top
